//--- rtl/cmp_ctrl_defines.svh
// Constants for the dual comparator control block: offsets, fields, resets.
// Assumes inclusion by bare name from rtl/ sources; definitions only.
`ifndef CMP_CTRL_DEFINES_SVH
`define CMP_CTRL_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define OFF_CONTROL 4'h0
`define OFF_FLAG 4'h4
// Control register field positions
`define BIT_CMP2_RESULT 7
`define BIT_CMP1_RESULT 6
`define BIT_CMP2_INVERT 5
`define BIT_CMP1_INVERT 4
`define BIT_INPUT_SWITCH 3
`define MODE_HI 2
`define MODE_LO 0
// Writable control bits reset: switch and inverts clear, mode off
`define CONTROL_RESET 6'h07
// Flag register: bit 0 is the change flag, write 1 to clear
`define BIT_CHANGE_FLAG 0
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/cmp_ctrl_pkg.sv
// Types shared by the dual comparator control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cmp_ctrl_pkg;
  // Eight comparator configurations
  typedef enum logic [2:0] {
    MODE_RESET_STATE = 3'h0,
    MODE_ONE_INDEP = 3'h1,
    MODE_TWO_INDEP = 3'h2,
    MODE_TWO_OUT = 3'h3,
    MODE_TWO_COMMON = 3'h4,
    MODE_COMMON_OUT = 3'h5,
    MODE_FOUR_MUX = 3'h6,
    MODE_OFF = 3'h7
  } cmp_mode_e;
endpackage
`default_nettype wire

//--- rtl/cmp_ctrl.sv
// Dual comparator control register, result sync, change flag, input routing.
// Assumes analog comparator raw outputs arrive as async levels; AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_ctrl_defines.svh"
module cmp_ctrl #(
  parameter int ADDR_W = 4 // Byte address width of the register window
) (
  input wire logic MCLK,
  input wire logic RESET,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Raw comparator outputs from the analog cells
  input wire logic CMP1_RAW,
  input wire logic CMP2_RAW,
  // Port A direction bits for the two result pins (1 = input)
  input wire logic PORT_A_DIRECTION_4,
  input wire logic PORT_A_DIRECTION_5,
  // Analog routing selects
  output logic [2:0] CMP_MODE_SELECT,
  output logic CMP1_NEG_FROM_CH3,
  output logic CMP2_NEG_FROM_CH2,
  output logic INTERNAL_VOLTAGE_REF_EN,
  output logic CMP1_INVERT_OUT,
  output logic CMP2_INVERT_OUT,
  // Result pins, enable low while driving
  output logic CMP1_PIN_O,
  output logic CMP1_PIN_OE_N,
  output logic CMP2_PIN_O,
  output logic CMP2_PIN_OE_N,
  // Change flag level toward the interrupt controller
  output logic CMP_CHANGE_FLAG
);

  // Elaboration check: word decode needs one address bit above the two byte lane bits
  if (ADDR_W < 3 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // Modes that drive comparator outputs onto pins
  function automatic logic drives_pins(input logic [2:0] m);
    drives_pins = (m == cmp_ctrl_pkg::MODE_TWO_OUT) || (m == cmp_ctrl_pkg::MODE_COMMON_OUT);
  endfunction

  // Register offset match on word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    logic [ADDR_W-1:0] off_w; // Offset at the window's width
    off_w = ADDR_W'(off);
    // Byte lane bits ignored: any byte inside the word selects it
    hit = (a[ADDR_W-1:2] == off_w[ADDR_W-1:2]);
  endfunction

  // Control state
  logic [5:0] ctrl_ff, nxt_ctrl; // Inverts, switch, mode
  logic [1:0] sync1_ff, nxt_sync1; // First sync stage, read by stage two only
  logic [1:0] sync2_ff, nxt_sync2; // Stable raw results
  logic [1:0] seen_ff, nxt_seen; // Result value last latched by an access
  logic flag_ff, nxt_flag; // Change flag
  // Bus state
  logic aw_hold_ff, nxt_aw_hold; // Write address taken
  logic [ADDR_W-1:0] aw_ff, nxt_aw;
  logic w_hold_ff, nxt_w_hold; // Write data taken
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0] ws_ff, nxt_ws;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  // Output registers
  logic [1:0] pin_o_ff, nxt_pin_o;
  logic [1:0] pin_oe_n_ff, nxt_pin_oe_n;
  logic [1:0] route_ff, nxt_route;
  logic vref_ff, nxt_vref;
  logic awready_ff, nxt_awready; // Write address slot free
  logic wready_ff, nxt_wready; // Write data slot free
  logic arready_ff, nxt_arready; // No read answer pending

  logic [1:0] result; // Inverted view of synced results
  logic [2:0] mode;
  logic wr_go, rd_go, ctl_access;

  assign mode = ctrl_ff[`MODE_HI:`MODE_LO];
  // Inversion applied after sync so writes to invert bits act at once
  assign result = sync2_ff ^ {ctrl_ff[`BIT_CMP2_INVERT], ctrl_ff[`BIT_CMP1_INVERT]};
  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign rd_go = S_AXI_ARVALID && !rvalid_ff;
  assign ctl_access = (wr_go && hit(aw_ff, `OFF_CONTROL)) || (rd_go && hit(S_AXI_ARADDR, `OFF_CONTROL));

  // Next state for synchroniser, control register, flag and bus
  always_comb begin
    nxt_sync1 = {CMP2_RAW, CMP1_RAW};
    nxt_sync2 = sync1_ff;
    nxt_ctrl = ctrl_ff;
    nxt_seen = seen_ff;
    nxt_flag = flag_ff;
    nxt_aw_hold = aw_hold_ff;
    nxt_aw = aw_ff;
    nxt_w_hold = w_hold_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    // Address and data accepted independently
    if (S_AXI_AWVALID && !aw_hold_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_aw = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_hold_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wd = S_AXI_WDATA;
      nxt_ws = S_AXI_WSTRB;
    end
    if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // Software clear of flag; hardware set below wins
    if (wr_go) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `RESP_OKAY;
      if (hit(aw_ff, `OFF_CONTROL)) begin
        if (ws_ff[0]) begin
          nxt_ctrl = wd_ff[5:0];
        end
      end else if (hit(aw_ff, `OFF_FLAG)) begin
        if (ws_ff[0] && wd_ff[`BIT_CHANGE_FLAG]) begin
          nxt_flag = 1'b0;
        end
      end else begin
        nxt_bresp = `RESP_SLVERR;
      end
    end
    if (S_AXI_RREADY && rvalid_ff) begin
      nxt_rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      if (hit(S_AXI_ARADDR, `OFF_CONTROL)) begin
        nxt_rdata = {24'h000000, result, ctrl_ff};
      end else if (hit(S_AXI_ARADDR, `OFF_FLAG)) begin
        nxt_rdata = {31'h00000000, flag_ff};
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `RESP_SLVERR;
      end
    end
    // Any control access re-latches the compare value, ending mismatch
    if (ctl_access) begin
      nxt_seen = result;
    end
    // Mismatch keeps setting the flag; set wins over clear
    if (result != seen_ff) begin
      nxt_flag = 1'b1;
    end
    // Readies kept as flops of their own so no port hangs off an inverter
    nxt_awready = !nxt_aw_hold;
    nxt_wready = !nxt_w_hold;
    nxt_arready = !nxt_rvalid;
  end

  // Next state of outputs toward analog side and pins
  always_comb begin
    nxt_route = 2'h0;
    nxt_vref = 1'b0;
    // Routing switch only meaningful in the multiplexed mode
    if (nxt_ctrl[`MODE_HI:`MODE_LO] == cmp_ctrl_pkg::MODE_FOUR_MUX) begin
      nxt_route = {2{nxt_ctrl[`BIT_INPUT_SWITCH]}};
      nxt_vref = 1'b1;
    end
    // Pin drives only in output modes and when direction is output
    nxt_pin_o = result;
    nxt_pin_oe_n[0] = !(drives_pins(mode) && !PORT_A_DIRECTION_4);
    nxt_pin_oe_n[1] = !(drives_pins(mode) && !PORT_A_DIRECTION_5);
  end

  // Register everything
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ctrl_ff <= `CONTROL_RESET;
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      seen_ff <= 2'h0;
      flag_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      aw_ff <= '0;
      w_hold_ff <= 1'b0;
      wd_ff <= 32'h00000000;
      ws_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
      pin_o_ff <= 2'h0;
      pin_oe_n_ff <= 2'h3;
      route_ff <= 2'h0;
      vref_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      seen_ff <= nxt_seen;
      flag_ff <= nxt_flag;
      aw_hold_ff <= nxt_aw_hold;
      aw_ff <= nxt_aw;
      w_hold_ff <= nxt_w_hold;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      pin_o_ff <= nxt_pin_o;
      pin_oe_n_ff <= nxt_pin_oe_n;
      route_ff <= nxt_route;
      vref_ff <= nxt_vref;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  // Port drive, all from flip-flops
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign CMP_MODE_SELECT = ctrl_ff[`MODE_HI:`MODE_LO];
  assign CMP1_INVERT_OUT = ctrl_ff[`BIT_CMP1_INVERT];
  assign CMP2_INVERT_OUT = ctrl_ff[`BIT_CMP2_INVERT];
  assign CMP1_NEG_FROM_CH3 = route_ff[0];
  assign CMP2_NEG_FROM_CH2 = route_ff[1];
  assign INTERNAL_VOLTAGE_REF_EN = vref_ff;
  assign CMP1_PIN_O = pin_o_ff[0];
  assign CMP2_PIN_O = pin_o_ff[1];
  assign CMP1_PIN_OE_N = pin_oe_n_ff[0];
  assign CMP2_PIN_OE_N = pin_oe_n_ff[1];
  assign CMP_CHANGE_FLAG = flag_ff;

  // Two-step result path: raw change then synced value
  sequence s_raw_moves;
    $changed(sync1_ff);
  endsequence
  sequence s_sync_follows;
    ##1 sync2_ff == $past(sync1_ff);
  endsequence

  a_reset_mode_off: assert property (@(posedge MCLK)
    $fell(RESET) |-> ctrl_ff[2:0] == 3'h7)
    else $error("mode not off after reset");
  a_sync_two_stage: assert property (@(posedge MCLK) disable iff (RESET)
    s_raw_moves |-> s_sync_follows)
    else $error("sync stage skipped");
  a_flag_on_change: assert property (@(posedge MCLK) disable iff (RESET)
    (result != seen_ff) |=> flag_ff)
    else $error("change flag missed");
  a_read_inverted: assert property (@(posedge MCLK) disable iff (RESET)
    rd_go && hit(S_AXI_ARADDR, `OFF_CONTROL) |=> rdata_ff[7:6] == $past(result))
    else $error("result bits wrong");
  a_invert_c1: assert property (@(posedge MCLK) disable iff (RESET)
    result[0] == (sync2_ff[0] ^ ctrl_ff[4]))
    else $error("cmp1 inversion wrong");
  a_write_ctrl: assert property (@(posedge MCLK) disable iff (RESET)
    wr_go && hit(aw_ff, `OFF_CONTROL) && ws_ff[0] |=> ctrl_ff == $past(wd_ff[5:0]))
    else $error("control write lost");
  // Reference enable and mode load from the same next value, so they match exactly
  a_vref_mode6: assert property (@(posedge MCLK) disable iff (RESET)
    vref_ff == (ctrl_ff[2:0] == 3'h6))
    else $error("reference not tied to mux mode");
  a_pin_dir: assert property (@(posedge MCLK) disable iff (RESET)
    PORT_A_DIRECTION_4 |=> CMP1_PIN_OE_N)
    else $error("pin driven while input");
  a_route_mode: assert property (@(posedge MCLK) disable iff (RESET)
    route_ff == {2{ctrl_ff[3] && (ctrl_ff[2:0] == 3'h6)}})
    else $error("switch routing wrong for mode");

endmodule
`default_nettype wire

//--- verification/cmp_analog_model.sv
// Behavioural analog front end: four pins and the reference feed two comparators.
// Assumes levels are unsigned codes and the raw outputs follow at once.
`timescale 1ns/100ps
`default_nettype none
module cmp_analog_model (
  input wire logic [7:0] AN0,
  input wire logic [7:0] AN1,
  input wire logic [7:0] AN2,
  input wire logic [7:0] AN3,
  input wire logic [7:0] VREF,
  input wire logic REF_EN,
  input wire logic NEG_CH3,
  input wire logic NEG_CH2,
  output logic CMP1_RAW,
  output logic CMP2_RAW
);
  // Reference takes both positive inputs only when enabled
  always_comb begin
    CMP1_RAW = (REF_EN ? VREF : AN3) > (NEG_CH3 ? AN3 : AN0);
    CMP2_RAW = (REF_EN ? VREF : AN2) > (NEG_CH2 ? AN2 : AN1);
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the comparator control block.
// Assumes the rtl package and defines are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "cmp_ctrl_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rdata_q;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, raw1, raw2, dir4 = 1, dir5 = 1;
  logic [2:0] mode;
  logic neg3, neg2, ref_en, inv1, inv2, p1, p1_oe_n, p2, p2_oe_n, flag;
  logic [7:0] a0 = 0, a1 = 0, a2 = 0, a3 = 0, vref = 8'h80;
  int errors = 0, total_checks = 0;
  // Free-running system clock
  always #10 mclk = ~mclk;
  cmp_ctrl i_cmp_ctrl (.MCLK(mclk), .RESET(reset), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CMP1_RAW(raw1), .CMP2_RAW(raw2),
    .PORT_A_DIRECTION_4(dir4), .PORT_A_DIRECTION_5(dir5), .CMP_MODE_SELECT(mode),
    .CMP1_NEG_FROM_CH3(neg3), .CMP2_NEG_FROM_CH2(neg2), .INTERNAL_VOLTAGE_REF_EN(ref_en),
    .CMP1_INVERT_OUT(inv1), .CMP2_INVERT_OUT(inv2), .CMP1_PIN_O(p1),
    .CMP1_PIN_OE_N(p1_oe_n), .CMP2_PIN_O(p2), .CMP2_PIN_OE_N(p2_oe_n),
    .CMP_CHANGE_FLAG(flag));
  cmp_analog_model i_cmp_analog_model (.AN0(a0), .AN1(a1), .AN2(a2), .AN3(a3),
    .VREF(vref), .REF_EN(ref_en), .NEG_CH3(neg3), .NEG_CH2(neg2),
    .CMP1_RAW(raw1), .CMP2_RAW(raw2));
  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A spent bound is a failure, not a hang
  task automatic tmo(input int n);
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
  endtask
  // One write; address and data released each when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid && n < 50);
    resp = bresp;
    bready <= 0;
    tmo(n);
  endtask
  // One read; data taken at the edge rvalid is seen
  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid && n < 50);
    resp = rresp;
    rdata_q = rdata;
    rready <= 0;
    tmo(n);
  endtask
  task automatic t_reset();
    rd(4'h0);
    `CHK("ctl", 8'h07, rdata_q[7:0])
    `CHK("mode", 3'h7, mode)
    `CHK("oe", 2'b11, {p1_oe_n, p2_oe_n})
  endtask
  // Every mode, switch set: reference and routing only in mode 6
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      wr(4'h0, 32'h08 | m);
      `CHK("bresp", `RESP_OKAY, resp)
      `CHK("mode", 3'(m), mode)
      `CHK("ref", 1'(m == 6), ref_en)
      `CHK("neg", {2{1'(m == 6)}}, {neg3, neg2})
    end
  endtask
  task automatic t_res();
    a0 <= 8'h10;
    a1 <= 8'hF0;
    wr(4'h0, 32'h06);
    repeat (4) @(posedge mclk);
    rd(4'h0);
    `CHK("res", 8'h46, rdata_q[7:0])
    wr(4'h0, 32'h36);
    repeat (4) @(posedge mclk);
    rd(4'h0);
    `CHK("inv", 8'hB6, rdata_q[7:0])
    `CHK("invout", 2'b11, {inv2, inv1})
  endtask
  // Flag cleared only after the control access ends the mismatch
  task automatic t_flag();
    rd(4'h0);
    wr(4'h4, 32'h01);
    rd(4'h4);
    `CHK("clr", 1'b0, rdata_q[0])
    a0 <= 8'hFF;
    repeat (5) @(posedge mclk);
    rd(4'h4);
    `CHK("set", 1'b1, rdata_q[0])
    `CHK("flagpin", 1'b1, flag)
    rd(4'h0);
    wr(4'h4, 32'h01);
    rd(4'h4);
    `CHK("clr2", 1'b0, rdata_q[0])
  endtask
  // Output mode: pin 1 driven, pin 2 held as input by direction
  task automatic t_pins();
    a3 <= 8'hC8;
    a0 <= 8'h0A;
    a2 <= 8'h00;
    a1 <= 8'h64;
    dir4 <= 0;
    dir5 <= 1;
    wr(4'h0, 32'h03);
    repeat (5) @(posedge mclk);
    `CHK("oe", 2'b01, {p1_oe_n, p2_oe_n})
    `CHK("pin", 1'b1, p1)
    rd(4'h0);
    `CHK("rd", 2'b01, rdata_q[7:6])
    `CHK("pin2", 1'b0, p2)
    // Common-reference output mode: both pins out, comparator 2 inverted
    dir5 <= 0;
    wr(4'h0, 32'h25);
    repeat (5) @(posedge mclk);
    `CHK("oe5", 2'b00, {p1_oe_n, p2_oe_n})
    `CHK("pin2inv", 1'b1, p2)
    `CHK("pin1", 1'b1, p1)
  endtask
  // Unmapped place: error answer and no side effect
  task automatic t_bad();
    rd(4'h8);
    `CHK("rresp", `RESP_SLVERR, resp)
    wr(4'h8, 32'h00);
    `CHK("bresp", `RESP_SLVERR, resp)
    // Low byte lane off: answered, control left alone
    wstrb <= 4'hE;
    wr(4'h0, 32'h07);
    `CHK("bresp0", `RESP_OKAY, resp)
    wstrb <= 4'hF;
    rd(4'h0);
    `CHK("keep", 6'h25, rdata_q[5:0])
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    t_reset();
    t_modes();
    t_res();
    t_flag();
    t_pins();
    t_bad();
    report_and_stop();
  end
endmodule
`default_nettype wire
